/* uld_pkg.sv */
// Constants shared by the register page decoder and loopback logic
package uld_pkg;
  // Locations on A2..A0
  localparam logic [2:0] LOC_DATA = 3'h0;
  localparam logic [2:0] LOC_IER = 3'h1;
  localparam logic [2:0] LOC_ISR = 3'h2;
  localparam logic [2:0] LOC_LCR = 3'h3;
  localparam logic [2:0] LOC_MCR = 3'h4;
  localparam logic [2:0] LOC_LSR = 3'h5;
  localparam logic [2:0] LOC_MSR = 3'h6;
  localparam logic [2:0] LOC_SPR = 3'h7;
  // Page key and divisor test value
  localparam logic [7:0] PAGE2_KEY = 8'hbf;
  localparam logic [7:0] DIV_ZERO = 8'h00;
  // Field positions
  localparam int LCR_DLAB = 7;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OP1 = 2;
  localparam int MCR_OP2 = 3;
  localparam int MCR_LOOP = 4;
  localparam int EFR_ENH = 4;
  localparam int EFR_ARTS = 6;
  localparam int EFR_ACTS = 7;
  // Bits that exist only with the enhanced enable
  localparam logic [7:0] IER_ENH = 8'hf0;
  localparam logic [7:0] ISR_ENH = 8'h30;
  localparam logic [7:0] FCR_ENH = 8'h30;
  localparam logic [7:0] MCR_ENH = 8'he0;
  localparam logic [7:0] MSR_ENH = 8'hf0;
  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic PIN_IDLE = 1'b1;
endpackage

/* uld_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module uld_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stage1 <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

/* uld_loop_mux.sv */
// Serial and modem path steering for normal and loopback operation
`timescale 1ns/1ps
module uld_loop_mux
  import uld_pkg::*;
(
  // Control
  input wire logic [7:0] modem_control,
  input wire logic [7:0] enhanced_function,
  // Serial paths
  input wire logic tsr_out,
  input wire logic rx_s,
  output logic next_tx,
  output logic next_rsr_in,
  // Modem pins, synchronised, active low
  input wire logic cts_s_n,
  input wire logic dsr_s_n,
  input wire logic cd_s_n,
  input wire logic ri_s_n,
  output logic [3:0] next_mo_n,
  // Status seen by the core, active high: cd ri dsr cts
  output logic [3:0] next_mstat,
  output logic next_arts,
  output logic next_acts
);
  logic loop;

  assign loop = modem_control[MCR_LOOP];

  always_comb
  begin
    if (loop)
    begin
      next_tx = PIN_IDLE;
      next_rsr_in = tsr_out;
      next_mo_n = {4{PIN_IDLE}};
      // External modem pins are not looked at here
      next_mstat = {modem_control[MCR_OP2], modem_control[MCR_OP1], modem_control[MCR_DTR],
                    modem_control[MCR_RTS]};
    end
    else
    begin
      next_tx = tsr_out;
      next_rsr_in = rx_s;
      next_mo_n = ~modem_control[3:0];
      next_mstat = ~{cd_s_n, ri_s_n, dsr_s_n, cts_s_n};
    end
    // Hardware flow control is withheld while looping back
    next_arts = enhanced_function[EFR_ARTS] & ~loop;
    next_acts = enhanced_function[EFR_ACTS] & ~loop;
  end
endmodule

/* uld_regs.sv */
// Host register page decoder with internal loopback steering
`timescale 1ns/1ps
// Overview of operation
// - Loopback is on exactly while modem control bit 4 is set.
// - In loopback the transmit shift output feeds the receive shift input.
// - In loopback transmit pin sits at mark, RTS and DTR deasserted.
// - In loopback external CTS, DSR, CD and RI pins are ignored.
// - All other register and data functions keep working in loopback.
// - Automatic RTS/CTS flow control is withheld during loopback.
// - Three address lines and the bus direction select the register.
// - Second page is reachable only while line control equals 0xBF.
// - Location 0, divisor bit clear: read receive, write transmit.
// - Divisor bit set, not 0xBF: locations 0 and 1 are divisor bytes.
// - Divisor zero in that page: reads give revision and device codes.
// - Divisor bit clear: location 1 is interrupt enable.
// - Divisor bit clear: location 2 reads status, writes FIFO control.
// - Line control at location 3 is always readable and writable.
// - Divisor bit clear: modem control at 4, scratch pad at 7.
// - Divisor bit clear: locations 5 and 6 read line and modem status.
// - With enhanced bit, writes at 5 and 6 load extra feature and pulse width.
// - At 0xBF: enhanced function at 2, flow characters at 4 to 7.
// - Extended bits act only with enhanced bit 4, else read 0.
// - Gated bits: upper enables, status 5:4, FIFO 5:4, modem 7:5, modem status 7:4.
module uld_regs
  import uld_pkg::*;
#(
  parameter logic [7:0] REV_CODE = 8'h01, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h5a // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] d_in,
  output logic [7:0] d_out,
  output logic d_oe,
  // Core status in
  input wire logic [7:0] rhr_data,
  input wire logic [7:0] isr_data,
  input wire logic [7:0] lsr_data,
  input wire logic [3:0] msr_delta,
  // Core strobes out
  output logic [7:0] wr_byte,
  output logic thr_wr,
  output logic fcr_wr,
  output logic rhr_read,
  output logic isr_read,
  output logic lsr_read,
  output logic msr_read,
  // Configuration out
  output logic [7:0] dll,
  output logic [7:0] baud_divisor_high,
  output logic [7:0] line_control,
  output logic [7:0] enhanced_function,
  output logic [7:0] xon1,
  output logic [7:0] xon2,
  output logic [7:0] xoff1,
  output logic [7:0] xoff2,
  output logic [7:0] ier_cfg,
  output logic [7:0] mcr_cfg,
  output logic [7:0] xfr_cfg,
  output logic [7:0] infrared_pulse_width_cfg,
  output logic loopback,
  output logic auto_rts_en,
  output logic auto_cts_en,
  // Serial paths
  input wire logic tsr_out,
  input wire logic rx,
  output logic rsr_in,
  output logic tx,
  // Modem pins
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic cd_n,
  input wire logic ri_n,
  output logic dtr_n,
  output logic rts_n,
  output logic op1_n,
  output logic op2_n,
  output logic [3:0] mstat
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] strb_s;
  logic [10:0] bus_s;
  logic [4:0] pins_s;

  uld_sync #(.W(3), .RST_VAL(3'h7)) u_strb (
    .mclk(mclk), .rst(rst), .din({cs_n, rd_n, wr_n}), .dout(strb_s)
  );
  uld_sync #(.W(11), .RST_VAL(11'h000)) u_bus (
    .mclk(mclk), .rst(rst), .din({addr, d_in}), .dout(bus_s)
  );
  uld_sync #(.W(5), .RST_VAL(5'h1f)) u_pins (
    .mclk(mclk), .rst(rst), .din({rx, cts_n, dsr_n, cd_n, ri_n}),
    .dout(pins_s)
  );

  // ------------------------------------------------------------
  // Strobe tracking
  // ------------------------------------------------------------
  logic wr_act;
  logic wr_act_q;
  logic rd_act;
  logic rd_act_q;
  logic commit;
  logic [2:0] w_loc;
  logic [7:0] w_val;

  assign wr_act = ~strb_s[2] & ~strb_s[0];
  assign rd_act = ~strb_s[2] & ~strb_s[1];
  // A write lands when the strobe ends, with what stood during it
  assign commit = wr_act_q & ~wr_act;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      w_loc <= LOC_DATA;
      w_val <= REG_RST;
    end
    else
    begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act)
      begin
        w_loc <= bus_s[10:8];
        w_val <= bus_s[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Page decode
  // ------------------------------------------------------------
  logic page2;
  logic dlab;
  logic enh;
  logic div_zero;
  logic [7:0] interrupt_enable;
  logic [7:0] modem_control;
  logic [7:0] scratch_pad;
  logic [7:0] extra_feature;
  logic [7:0] infrared_pulse_width;

  assign page2 = (line_control == PAGE2_KEY);
  assign dlab = line_control[LCR_DLAB];
  assign enh = enhanced_function[EFR_ENH];
  assign div_zero = (dll == DIV_ZERO) && (baud_divisor_high == DIV_ZERO);

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dll <= REG_RST;
      baud_divisor_high <= REG_RST;
      interrupt_enable <= REG_RST;
      line_control <= REG_RST;
      modem_control <= REG_RST;
      scratch_pad <= REG_RST;
      enhanced_function <= REG_RST;
      xon1 <= REG_RST;
      xon2 <= REG_RST;
      xoff1 <= REG_RST;
      xoff2 <= REG_RST;
      extra_feature <= REG_RST;
      infrared_pulse_width <= REG_RST;
    end
    else if (commit)
    begin
      // Read-only places fall through with no effect
      unique case (w_loc)
        LOC_DATA:
          if (dlab) dll <= w_val;
        LOC_IER:
          if (dlab) baud_divisor_high <= w_val;
          else interrupt_enable <= w_val;
        LOC_ISR:
          if (page2) enhanced_function <= w_val;
        LOC_LCR:
          line_control <= w_val;
        LOC_MCR:
          if (page2) xon1 <= w_val;
          else modem_control <= w_val;
        LOC_LSR:
          if (page2) xon2 <= w_val;
          else if (enh) extra_feature <= w_val;
        LOC_MSR:
          if (page2) xoff1 <= w_val;
          else if (enh) infrared_pulse_width <= w_val;
        LOC_SPR:
          if (page2) xoff2 <= w_val;
          else scratch_pad <= w_val;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Write strobes to the core
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      thr_wr <= 1'b0;
      fcr_wr <= 1'b0;
      wr_byte <= REG_RST;
    end
    else
    begin
      thr_wr <= commit && w_loc == LOC_DATA && !dlab;
      fcr_wr <= commit && w_loc == LOC_ISR && !dlab;
      if (commit && w_loc == LOC_ISR)
        wr_byte <= enh ? w_val : (w_val & ~FCR_ENH);
      else if (commit)
        wr_byte <= w_val;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] msr_val;
  logic [2:0] r_loc;
  logic rd_start;

  assign r_loc = bus_s[10:8];
  assign rd_start = rd_act & ~rd_act_q;
  assign msr_val = {mstat, msr_delta};

  always_comb
  begin
    rd_mux = REG_RST;
    unique case (r_loc)
      LOC_DATA:
        if (!dlab) rd_mux = rhr_data;
        else if (!page2 && div_zero) rd_mux = REV_CODE;
        else rd_mux = dll;
      LOC_IER:
        if (!dlab) rd_mux = enh ? interrupt_enable : (interrupt_enable & ~IER_ENH);
        else if (!page2 && div_zero) rd_mux = DEV_ID;
        else rd_mux = baud_divisor_high;
      LOC_ISR:
        if (page2) rd_mux = enhanced_function;
        else rd_mux = enh ? isr_data : (isr_data & ~ISR_ENH);
      LOC_LCR:
        rd_mux = line_control;
      LOC_MCR:
        if (page2) rd_mux = xon1;
        else rd_mux = mcr_cfg;
      LOC_LSR:
        if (page2) rd_mux = xon2;
        else rd_mux = lsr_data;
      LOC_MSR:
        if (page2) rd_mux = xoff1;
        else rd_mux = enh ? msr_val : (msr_val & ~MSR_ENH);
      LOC_SPR:
        if (page2) rd_mux = xoff2;
        else rd_mux = scratch_pad;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      d_out <= REG_RST;
      d_oe <= 1'b0;
      rhr_read <= 1'b0;
      isr_read <= 1'b0;
      lsr_read <= 1'b0;
      msr_read <= 1'b0;
    end
    else
    begin
      d_out <= rd_mux;
      d_oe <= rd_act;
      // One pulse per read so the core can pop or clear once
      rhr_read <= rd_start && r_loc == LOC_DATA && !dlab;
      isr_read <= rd_start && r_loc == LOC_ISR && !page2;
      lsr_read <= rd_start && r_loc == LOC_LSR && !page2;
      msr_read <= rd_start && r_loc == LOC_MSR && !page2;
    end
  end

  // ------------------------------------------------------------
  // Gated configuration
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ier_cfg <= REG_RST;
      mcr_cfg <= REG_RST;
      xfr_cfg <= REG_RST;
      infrared_pulse_width_cfg <= REG_RST;
    end
    else
    begin
      ier_cfg <= enh ? interrupt_enable : (interrupt_enable & ~IER_ENH);
      mcr_cfg <= enh ? modem_control : (modem_control & ~MCR_ENH);
      xfr_cfg <= enh ? extra_feature : REG_RST;
      infrared_pulse_width_cfg <= enh ? infrared_pulse_width : REG_RST;
    end
  end

  // ------------------------------------------------------------
  // Loopback steering
  // ------------------------------------------------------------
  logic next_tx;
  logic next_rsr_in;
  logic [3:0] next_mo_n;
  logic [3:0] next_mstat;
  logic next_arts;
  logic next_acts;

  uld_loop_mux u_loop (
    .modem_control(modem_control), .enhanced_function(enhanced_function), .tsr_out(tsr_out), .rx_s(pins_s[4]),
    .next_tx(next_tx), .next_rsr_in(next_rsr_in),
    .cts_s_n(pins_s[3]), .dsr_s_n(pins_s[2]), .cd_s_n(pins_s[1]),
    .ri_s_n(pins_s[0]), .next_mo_n(next_mo_n),
    .next_mstat(next_mstat), .next_arts(next_arts), .next_acts(next_acts)
  );

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx <= PIN_IDLE;
      rsr_in <= PIN_IDLE;
      {op2_n, op1_n, rts_n, dtr_n} <= {4{PIN_IDLE}};
      mstat <= 4'h0;
      loopback <= 1'b0;
      auto_rts_en <= 1'b0;
      auto_cts_en <= 1'b0;
    end
    else
    begin
      tx <= next_tx;
      rsr_in <= next_rsr_in;
      {op2_n, op1_n, rts_n, dtr_n} <= next_mo_n;
      mstat <= next_mstat;
      loopback <= modem_control[MCR_LOOP];
      auto_rts_en <= next_arts;
      auto_cts_en <= next_acts;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_loop_follow: assert property (
    loopback == $past(modem_control[MCR_LOOP]))
    else $error("loopback flag does not follow control bit");
  a_loop_rx_route: assert property (
    modem_control[MCR_LOOP] |=> rsr_in == $past(tsr_out))
    else $error("receive input not fed from transmit shift output");
  a_loop_pins_idle: assert property (
    modem_control[MCR_LOOP] |=> tx && rts_n && dtr_n)
    else $error("pins not idle during loopback");
  a_loop_modem_ign: assert property (
    modem_control[MCR_LOOP] |=> mstat[0] == $past(modem_control[MCR_RTS]))
    else $error("external modem input seen in loopback");
  a_norm_rx_path: assert property (
    !modem_control[MCR_LOOP] |=> rsr_in == $past(pins_s[4]))
    else $error("receive path wrong outside loopback");
  a_flow_off: assert property (
    modem_control[MCR_LOOP] |=> !auto_rts_en && !auto_cts_en)
    else $error("auto flow control active in loopback");
  a_page2_efr: assert property (
    commit && w_loc == LOC_ISR && page2 |=> enhanced_function == $past(w_val))
    else $error("enhanced function write lost");
  a_lcr_any: assert property (
    commit && w_loc == LOC_LCR |=> line_control == $past(w_val))
    else $error("line control write lost");
  a_ro_write: assert property (
    commit && w_loc == LOC_LSR && !page2 && !enh
    |=> $stable(modem_control) && $stable(scratch_pad) && $stable(extra_feature))
    else $error("read-only write altered state");
  a_ier_gate: assert property (
    !dlab && !enh && r_loc == LOC_IER |=> d_out[7:4] == 4'h0)
    else $error("gated enable bits visible");
  a_rev_read: assert property (
    dlab && !page2 && div_zero && r_loc == LOC_DATA |=> d_out == REV_CODE)
    else $error("revision code not returned");

  c_loop_write: cover property (commit && w_loc == LOC_MCR && w_val[4]);
  c_page2: cover property (commit && page2 && w_loc == LOC_SPR);
  c_thr: cover property (thr_wr && loopback);
endmodule

/* uld_host.sv */
// Host processor model driving the parallel register bus
`timescale 1ns/1ps
module uld_host (
  // Clock
  input wire logic mclk,
  // Bus strobes and address
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [2:0] addr,
  // Data
  output logic [7:0] d_in,
  input wire logic [7:0] d_out,
  input wire logic d_oe
);
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 3'h0;
    d_in = 8'hff;
  end

  // Released lines show the inverse so stale values never look valid
  task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    d_in = d;
    repeat (4) @(posedge mclk);
    #1;
    cs_n = 1'b1;
    wr_n = 1'b1;
    addr = ~a;
    d_in = ~d;
    repeat (5) @(posedge mclk);
    #1;
  endtask

  task automatic bus_read(input logic [2:0] a, output logic [7:0] d,
                          output logic ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(posedge mclk);
    #1;
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    for (n = 0; n < 8; n++)
    begin
      @(posedge mclk);
      #1;
      if (d_oe === 1'b1)
      begin
        ok = 1'b1;
        d = d_out;
        break;
      end
    end
    cs_n = 1'b1;
    rd_n = 1'b1;
    addr = ~a;
    repeat (5) @(posedge mclk);
    #1;
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the register page decoder and loopback
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top
  import uld_pkg::*;
;
  localparam logic [7:0] REV = 8'h2c; // Arbitrary value
  localparam logic [7:0] DEV = 8'h71; // Arbitrary value
  int n_tests = 0;
  int fail_count = 0;
  int thr_cnt = 0;
  int fcr_cnt = 0;
  int rhr_cnt = 0;
  int isr_cnt = 0;
  int lsr_cnt = 0;
  int msr_cnt = 0;
  logic mclk, rst, cs_n, rd_n, wr_n, d_oe;
  logic [2:0] addr;
  logic [7:0] d_in, d_out, rhr_data, isr_data, lsr_data, wr_byte;
  logic [3:0] msr_delta, mstat;
  logic thr_wr, fcr_wr, rhr_read, isr_read, lsr_read, msr_read;
  logic [7:0] dll, baud_divisor_high, line_control, enhanced_function, xon1, xon2, xoff1, xoff2;
  logic [7:0] ier_cfg, mcr_cfg, xfr_cfg, infrared_pulse_width_cfg;
  logic loopback, auto_rts_en, auto_cts_en, tsr_out, rx, rsr_in, tx;
  logic cts_n, dsr_n, cd_n, ri_n, dtr_n, rts_n, op1_n, op2_n;

  uld_regs #(.REV_CODE(REV), .DEV_ID(DEV)) uld_regs_inst (
    .mclk, .rst, .cs_n, .rd_n, .wr_n, .addr, .d_in, .d_out, .d_oe,
    .rhr_data, .isr_data, .lsr_data, .msr_delta, .wr_byte, .thr_wr,
    .fcr_wr, .rhr_read, .isr_read, .lsr_read, .msr_read, .dll, .baud_divisor_high,
    .line_control, .enhanced_function, .xon1, .xon2, .xoff1, .xoff2, .ier_cfg, .mcr_cfg,
    .xfr_cfg, .infrared_pulse_width_cfg, .loopback, .auto_rts_en, .auto_cts_en,
    .tsr_out, .rx, .rsr_in, .tx, .cts_n, .dsr_n, .cd_n, .ri_n, .dtr_n,
    .rts_n, .op1_n, .op2_n, .mstat
  );

  uld_host uld_host_inst (
    .mclk, .cs_n, .rd_n, .wr_n, .addr, .d_in, .d_out, .d_oe
  );

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Pulses last one cycle, so count them rather than poll them
  always @(posedge mclk)
  begin
    if (thr_wr === 1'b1) thr_cnt++;
    if (fcr_wr === 1'b1) fcr_cnt++;
    if (rhr_read === 1'b1) rhr_cnt++;
    if (isr_read === 1'b1) isr_cnt++;
    if (lsr_read === 1'b1) lsr_cnt++;
    if (msr_read === 1'b1) msr_cnt++;
  end

  // ----------------------------------------
  // Bus helpers and verdict
  // ----------------------------------------
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    uld_host_inst.bus_write(a, d);
  endtask

  task automatic chk_rd(input string nm, input logic [2:0] a,
                        input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    uld_host_inst.bus_read(a, d, ok);
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("Error read strobe expected 1 seen %b", ok);
      give_verdict();
    end
    `CHK(nm, e, d)
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK("loopback", 1'b0, loopback)
    `CHK("dtr_n", 1'b1, dtr_n)
    `CHK("d_oe", 1'b0, d_oe)
    `CHK("efr", 8'h00, enhanced_function)
  endtask

  task automatic t_base();
    int t0;
    wr(LOC_LCR, 8'h03);
    chk_rd("lcr", LOC_LCR, 8'h03);
    wr(LOC_IER, 8'hff);
    `CHK("ier_cfg", 8'h0f, ier_cfg)
    chk_rd("ier", LOC_IER, 8'h0f);
    wr(LOC_SPR, 8'ha5);
    chk_rd("spr", LOC_SPR, 8'ha5);
    wr(LOC_MCR, 8'he3);
    `CHK("mcr_cfg", 8'h03, mcr_cfg)
    chk_rd("mcr", LOC_MCR, 8'h03);
    `CHK("rts_n", 1'b0, rts_n)
    t0 = rhr_cnt;
    rhr_data = 8'h3c;
    chk_rd("rhr", LOC_DATA, 8'h3c);
    `CHK("rhr pulse", t0 + 1, rhr_cnt)
    t0 = thr_cnt;
    wr(LOC_DATA, 8'h5a);
    `CHK("thr pulse", t0 + 1, thr_cnt)
    `CHK("wr_byte", 8'h5a, wr_byte)
    isr_data = 8'hff;
    t0 = isr_cnt;
    chk_rd("isr", LOC_ISR, 8'hcf);
    `CHK("isr pulse", t0 + 1, isr_cnt)
    t0 = fcr_cnt;
    wr(LOC_ISR, 8'hff);
    `CHK("fcr pulse", t0 + 1, fcr_cnt)
    `CHK("fcr byte", 8'hcf, wr_byte)
    lsr_data = 8'h61;
    wr(LOC_LSR, 8'h77);
    `CHK("xfr_cfg", 8'h00, xfr_cfg)
    t0 = lsr_cnt;
    chk_rd("lsr", LOC_LSR, 8'h61);
    `CHK("lsr pulse", t0 + 1, lsr_cnt)
    wr(LOC_MSR, 8'h55);
    `CHK("infrared_pulse_width_cfg", 8'h00, infrared_pulse_width_cfg)
    // Live modem pins make the gated upper status bits visible if unmasked
    msr_delta = 4'h9;
    {cts_n, dsr_n, cd_n, ri_n} = 4'h0;
    t0 = msr_cnt;
    chk_rd("msr", LOC_MSR, 8'h09);
    `CHK("msr pulse", t0 + 1, msr_cnt)
    {cts_n, dsr_n, cd_n, ri_n} = 4'hf;
  endtask

  task automatic t_divisor();
    int t0;
    wr(LOC_LCR, 8'h83);
    chk_rd("revision", LOC_DATA, REV);
    chk_rd("ident", LOC_IER, DEV);
    t0 = thr_cnt;
    wr(LOC_DATA, 8'h12);
    wr(LOC_IER, 8'h34);
    `CHK("thr pulse", t0, thr_cnt)
    `CHK("dll", 8'h12, dll)
    `CHK("dlm", 8'h34, baud_divisor_high)
    chk_rd("dll", LOC_DATA, 8'h12);
    chk_rd("dlm", LOC_IER, 8'h34);
    wr(LOC_LCR, 8'h03);
    chk_rd("ier", LOC_IER, 8'h0f);
  endtask

  task automatic t_enhanced();
    int a;
    int t0;
    wr(LOC_LCR, PAGE2_KEY);
    wr(LOC_ISR, 8'hd0);
    t0 = isr_cnt;
    chk_rd("efr", LOC_ISR, 8'hd0);
    `CHK("isr pulse", t0, isr_cnt)
    `CHK("auto_cts_en", 1'b1, auto_cts_en)
    for (a = 4; a < 8; a++)
      wr(3'(a), 8'(8'h40 + a));
    for (a = 4; a < 8; a++)
      chk_rd("flow char", 3'(a), 8'(8'h40 + a));
    `CHK("xoff2", 8'h47, xoff2)
    wr(LOC_LCR, 8'h03);
    wr(LOC_ISR, 8'h00);
    `CHK("efr kept", 8'hd0, enhanced_function)
    chk_rd("isr", LOC_ISR, 8'hff);
    wr(LOC_LSR, 8'h3c);
    `CHK("xfr_cfg", 8'h3c, xfr_cfg)
    wr(LOC_MSR, 8'h5b);
    `CHK("infrared_pulse_width_cfg", 8'h5b, infrared_pulse_width_cfg)
    wr(LOC_MCR, 8'he3);
    `CHK("mcr_cfg", 8'he3, mcr_cfg)
    chk_rd("ier", LOC_IER, 8'hff);
  endtask

  task automatic t_loopback();
    int t0;
    {cts_n, dsr_n, cd_n, ri_n} = 4'h0;
    tsr_out = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    `CHK("mstat pins", 4'hf, mstat)
    `CHK("tx", 1'b0, tx)
    chk_rd("msr pins", LOC_MSR, 8'hf9);
    rx = 1'b1;
    wr(LOC_MCR, 8'h13);
    `CHK("loopback", 1'b1, loopback)
    `CHK("tx mark", 1'b1, tx)
    `CHK("dtr_n", 1'b1, dtr_n)
    `CHK("rts_n", 1'b1, rts_n)
    `CHK("rsr_in", 1'b0, rsr_in)
    `CHK("mstat", 4'h3, mstat)
    `CHK("auto_rts_en", 1'b0, auto_rts_en)
    `CHK("auto_cts_en", 1'b0, auto_cts_en)
    tsr_out = 1'b1;
    {cts_n, dsr_n, cd_n, ri_n} = 4'hf;
    repeat (4) @(posedge mclk);
    #1;
    `CHK("rsr_in", 1'b1, rsr_in)
    `CHK("mstat", 4'h3, mstat)
    wr(LOC_SPR, 8'h69);
    chk_rd("spr", LOC_SPR, 8'h69);
    t0 = thr_cnt;
    wr(LOC_DATA, 8'ha5);
    `CHK("thr pulse", t0 + 1, thr_cnt)
    // Output bits set, so only the loopback override can hold the pins high
    wr(LOC_MCR, 8'h1c);
    `CHK("op1_n", 1'b1, op1_n)
    `CHK("op2_n", 1'b1, op2_n)
    chk_rd("msr loop", LOC_MSR, 8'hc9);
    tsr_out = 1'b0;
    wr(LOC_MCR, 8'h03);
    `CHK("loopback", 1'b0, loopback)
    `CHK("tx", 1'b0, tx)
    `CHK("dtr_n", 1'b0, dtr_n)
    `CHK("rsr_in", 1'b1, rsr_in)
    `CHK("mstat", 4'h0, mstat)
    `CHK("auto_rts_en", 1'b1, auto_rts_en)
  endtask

  initial
  begin
    rst = 1'b1;
    rhr_data = 8'h00;
    isr_data = 8'h00;
    lsr_data = 8'h00;
    msr_delta = 4'h0;
    tsr_out = 1'b1;
    rx = 1'b1;
    {cts_n, dsr_n, cd_n, ri_n} = 4'hf;
    repeat (6) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    t_base();
    t_divisor();
    t_enhanced();
    t_loopback();
    give_verdict();
  end
endmodule
